//--- design/cmp_timer.sv
// dual-mode compare timer: 16-bit counter or two 8-bit counters
// assumes a single ahb-lite master, word transfers, async pins for the
// event input and the sub-clock
`timescale 1ns/10ps
module cmp_timer (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic event_count_input_in,
    input wire logic subclk_in,
    output logic toggle_out_upper_out,
    output logic toggle_out_lower_out,
    output logic irq_upper_out,
    output logic irq_lower_out
);
    import cmp_timer_pkg::*;

    // ========================================
    // ahb-lite slave
    logic rd_pend_q;
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic accept;
    logic [7:0] wd;

    assign hreadyout_out = !rd_pend_q;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;
    assign wd = hwdata_in[7:0];
    assign accept = hsel_in && htrans_in[1] && hready_in &&
                    (hsize_in == HSIZE_WORD);

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            rd_pend_q <= accept && !hwrite_in;
            wr_pend_q <= accept && hwrite_in;
            if (accept) begin
                addr_q <= haddr_in;
            end
        end
    end

    logic wr_ctrl, wr_stat, wr_misc;
    logic wr_cnt_h, wr_cnt_l, wr_cmp_h, wr_cmp_l;
    logic rd_stat, rd_cnt_h;
    assign wr_ctrl = wr_pend_q && (addr_q == OFF_CTRL);
    assign wr_stat = wr_pend_q && (addr_q == OFF_STAT);
    assign wr_misc = wr_pend_q && (addr_q == OFF_MISC);
    assign wr_cnt_h = wr_pend_q && (addr_q == OFF_CNT_H);
    assign wr_cnt_l = wr_pend_q && (addr_q == OFF_CNT_L);
    assign wr_cmp_h = wr_pend_q && (addr_q == OFF_CMP_H);
    assign wr_cmp_l = wr_pend_q && (addr_q == OFF_CMP_L);
    assign rd_stat = rd_pend_q && (addr_q == OFF_STAT);
    assign rd_cnt_h = rd_pend_q && (addr_q == OFF_CNT_H);

    // ========================================
    // registers
    logic [7:0] ctrl_q;
    logic [3:0] sctl_q;
    logic [3:0] flag_q;
    logic [3:0] armed_q;
    logic [7:0] misc_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] cmp_q;
    logic [15:0] cmp_d;
    logic [7:0] temp_q;
    logic mode8;
    logic [2:0] sel_h, sel_l;
    logic [7:0] stat_rd;

    assign mode8 = ctrl_q[CTRL_SEL_H + SEL_MSB];
    assign sel_h = ctrl_q[CTRL_SEL_H +: 3];
    assign sel_l = ctrl_q[CTRL_SEL_L +: 3];
    assign stat_rd = {flag_q[3], flag_q[2], sctl_q[3:2],
                      flag_q[1], flag_q[0], sctl_q[1:0]};

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ctrl_q <= CTRL_RST;
            misc_q <= MISC_RST;
            sctl_q <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wd;
            end
            if (wr_misc) begin
                misc_q <= {4'h0, wd[3:0]};
            end
            if (wr_stat) begin
                sctl_q <= {wd[STAT_OVIE_H], wd[STAT_CCLR_H],
                           wd[STAT_OVIE_L], wd[STAT_CCLR_L]};
            end
        end
    end

    // read data, with the temporary byte for 16-bit counter reads
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            case (addr_q)
                OFF_CTRL: hrdata_q <= {24'h0, ctrl_q};
                OFF_STAT: hrdata_q <= {24'h0, stat_rd};
                OFF_CNT_H: hrdata_q <= {24'h0, cnt_q[15:8]};
                OFF_CNT_L: hrdata_q <= {24'h0,
                                        mode8 ? cnt_q[7:0] : temp_q};
                OFF_CMP_H: hrdata_q <= {24'h0, cmp_q[15:8]};
                OFF_CMP_L: hrdata_q <= {24'h0, cmp_q[7:0]};
                OFF_MISC: hrdata_q <= {24'h0, misc_q};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            temp_q <= 8'h00;
        end else if (!mode8 && (wr_cnt_h || wr_cmp_h)) begin
            temp_q <= wd;
        end else if (!mode8 && rd_cnt_h) begin
            temp_q <= cnt_q[7:0];
        end
    end

    // ========================================
    // clock sources
    logic [PRESC_W-1:0] presc_q;
    logic en32, en16, en4;
    logic sub_s1_q, sub_s2_q, sub_prev_q;
    logic [1:0] subdiv_q;
    logic en_sub4;
    logic ev_s1_q, ev_s2_q, ev_prev_q;
    logic ev_tick;

    assign en32 = (presc_q & MASK_DIV32) == MASK_DIV32;
    assign en16 = (presc_q & MASK_DIV16) == MASK_DIV16;
    assign en4 = (presc_q & MASK_DIV4) == MASK_DIV4;
    assign en_sub4 = sub_s2_q && !sub_prev_q && (subdiv_q == MASK_SUB4);
    assign ev_tick = misc_q[MISC_EDGE] ? (ev_s2_q && !ev_prev_q)
                                       : (!ev_s2_q && ev_prev_q);

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_prev_q <= 1'b0;
            subdiv_q <= 2'h0;
        end else begin
            sub_s1_q <= subclk_in;
            sub_s2_q <= sub_s1_q;
            sub_prev_q <= sub_s2_q;
            if (sub_s2_q && !sub_prev_q) begin
                subdiv_q <= subdiv_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ev_s1_q <= 1'b0;
            ev_s2_q <= 1'b0;
            ev_prev_q <= 1'b0;
        end else begin
            ev_s1_q <= event_count_input_in;
            ev_s2_q <= ev_s1_q;
            ev_prev_q <= ev_s2_q;
        end
    end

    // one count enable for a three-bit select field
    function automatic logic sel_tick(input logic [2:0] sel);
        logic t;
        t = 1'b0;
        if (misc_q[MISC_SUBMODE]) begin
            t = sel[SEL_MSB] && (clk_src_t'(sel[1:0]) == SRC_SUB4) &&
                en_sub4;
        end else if (!sel[SEL_MSB]) begin
            t = ev_tick;
        end else begin
            case (clk_src_t'(sel[1:0]))
                SRC_DIV32: t = en32;
                SRC_DIV16: t = en16;
                SRC_DIV4: t = en4;
                SRC_SUB4: t = en_sub4;
                default: t = 1'b0;
            endcase
        end
        return t;
    endfunction : sel_tick

    // ========================================
    // compare, wrap and counter
    logic tick_l, tick_h;
    logic match16, match_l, match_h;
    logic ovf16, ovf_l, ovf_h;
    logic clr_h, clr_l;

    // a process, not an assign, so the enables read inside the function
    // wake it up as well
    always_comb begin
        tick_l = sel_tick(sel_l);
        tick_h = mode8 && sel_tick(sel_h);
    end
    assign clr_h = sctl_q[2];
    assign clr_l = sctl_q[0];

    always_comb begin
        cmp_d = cmp_q;
        if (wr_cmp_h && mode8) begin
            cmp_d[15:8] = wd;
        end
        if (wr_cmp_l) begin
            cmp_d[7:0] = wd;
            if (!mode8) begin
                cmp_d[15:8] = temp_q;
            end
        end
    end

    // the written compare value is the one matched against
    assign match16 = !mode8 && tick_l && (cnt_q == cmp_d);
    assign match_l = tick_l && (cnt_q[7:0] == cmp_d[7:0]);
    assign match_h = tick_h && (cnt_q[15:8] == cmp_d[15:8]);
    assign ovf16 = !mode8 && tick_l && (cnt_q == 16'hFFFF) &&
                   !wr_cnt_l;
    assign ovf_l = tick_l && (cnt_q[7:0] == BYTE_ONES) &&
                   !wr_cnt_l;
    assign ovf_h = mode8 && tick_h && (cnt_q[15:8] == BYTE_ONES) &&
                   !wr_cnt_h;

    always_comb begin
        cnt_d = cnt_q;
        if (!mode8) begin
            if (wr_cnt_l) begin
                cnt_d = {temp_q, wd};
            end else if (tick_l) begin
                cnt_d = (match16 && clr_h) ? 16'h0000
                                           : cnt_q + 16'h0001;
            end
        end else begin
            if (wr_cnt_l) begin
                cnt_d[7:0] = wd;
            end else if (tick_l) begin
                cnt_d[7:0] = (match_l && clr_l) ? 8'h00
                                                : cnt_q[7:0] + 8'h01;
            end
            if (wr_cnt_h) begin
                cnt_d[15:8] = wd;
            end else if (tick_h) begin
                cnt_d[15:8] = (match_h && clr_h) ? 8'h00
                                                 : cnt_q[15:8] + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cnt_q <= CNT_RST;
            cmp_q <= CMP_RST;
        end else begin
            cnt_q <= cnt_d;
            cmp_q <= cmp_d;
        end
    end

    // ========================================
    // flags: set beats clear, clear needs a prior read of 1
    logic [3:0] flag_set;
    logic [3:0] flag_wd;
    assign flag_set = {ovf16 || ovf_h, match16 || match_h,
                       ovf_l, match_l};
    assign flag_wd = {wd[STAT_OVF_H], wd[STAT_CMF_H],
                      wd[STAT_OVF_L], wd[STAT_CMF_L]};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_flag
            always_ff @(posedge mclk_in) begin
                if (srst_in) begin
                    flag_q[g] <= 1'b0;
                    armed_q[g] <= 1'b0;
                end else begin
                    if (flag_set[g]) begin
                        flag_q[g] <= 1'b1;
                    end else if (wr_stat && armed_q[g] && !flag_wd[g]) begin
                        flag_q[g] <= 1'b0;
                    end
                    if (rd_stat) begin
                        armed_q[g] <= flag_q[g];
                    end else if (wr_stat) begin
                        armed_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign irq_upper_out = misc_q[MISC_IEN_H] &&
        (flag_q[2] || (flag_q[3] && sctl_q[3]));
    assign irq_lower_out = misc_q[MISC_IEN_L] &&
        (flag_q[0] || (flag_q[1] && sctl_q[1]));

    // ========================================
    // toggle pins; in 16-bit mode the lower pin still toggles on each lower-byte match, except in a cycle with a control write
    logic pin_h_q, pin_l_q;
    assign toggle_out_upper_out = pin_h_q;
    assign toggle_out_lower_out = pin_l_q;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pin_h_q <= 1'b0;
            pin_l_q <= 1'b0;
        end else if (wr_ctrl) begin
            pin_h_q <= wd[CTRL_LVL_H];
            pin_l_q <= wd[CTRL_LVL_L];
        end else begin
            if (match16 || match_h) begin
                pin_h_q <= !pin_h_q;
            end
            if (match_l) begin
                pin_l_q <= !pin_l_q;
            end
        end
    end

    // ========================================
    // assertions
    sequence s_read_set;
        rd_stat && flag_q[2];
    endsequence

    sequence s_clear_write;
        wr_stat && !flag_wd[0] && !flag_set[0];
    endsequence

    property p_reset;
        @(posedge mclk_in) $past(srst_in) |->
            cnt_q == 16'h0000 && cmp_q == 16'hFFFF && ctrl_q == 8'h00 &&
            stat_rd == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset");

    property p_match_flag;
        @(posedge mclk_in) disable iff (srst_in)
            (match16 || match_h) |=> flag_q[2] ##0 irq_upper_out ==
            misc_q[MISC_IEN_H];
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("upper match flag");

    property p_clear16;
        @(posedge mclk_in) disable iff (srst_in)
            match16 && clr_h && !wr_cnt_l |=> cnt_q == 16'h0000;
    endproperty
    a_clear16: assert property (p_clear16)
        else $error("no clear on match");

    property p_wrap16;
        @(posedge mclk_in) disable iff (srst_in)
            !mode8 && tick_l && cnt_q == 16'hFFFF && !wr_cnt_l
            && !wr_ctrl |=> cnt_q == 16'h0000 && flag_q[3];
    endproperty
    a_wrap16: assert property (p_wrap16)
        else $error("wrap flag missing");

    property p_toggle;
        @(posedge mclk_in) disable iff (srst_in)
            match_l && !wr_ctrl |=> pin_l_q != $past(pin_l_q);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pin not toggled");

    property p_ctrl_wins;
        @(posedge mclk_in) disable iff (srst_in)
            wr_ctrl |=> pin_h_q == $past(wd[CTRL_LVL_H]);
    endproperty
    a_ctrl_wins: assert property (p_ctrl_wins)
        else $error("level write lost");

    property p_tick_only;
        @(posedge mclk_in) disable iff (srst_in)
            !tick_l |-> !match_l && !match16;
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("match without tick");

    property p_submode;
        @(posedge mclk_in) disable iff (srst_in)
            misc_q[MISC_SUBMODE] && sel_l != 3'h7 |-> !tick_l;
    endproperty
    a_submode: assert property (p_submode)
        else $error("counting off sub-clock");

    property p_ovf_suppress;
        @(posedge mclk_in) disable iff (srst_in)
            wr_cnt_l |-> !ovf_l && !ovf16;
    endproperty
    a_ovf_suppress: assert property (p_ovf_suppress)
        else $error("wrap not suppressed");

    property p_flag_clear;
        @(posedge mclk_in) disable iff (srst_in)
            armed_q[0] && flag_q[0] ##0 s_clear_write |=> !flag_q[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared");

    property p_flag_armed;
        @(posedge mclk_in) disable iff (srst_in)
            s_read_set |=> armed_q[2];
    endproperty
    a_flag_armed: assert property (p_flag_armed)
        else $error("flag read not armed");
endmodule : cmp_timer

//--- inc/cmp_timer_pkg.sv
// constants for the dual-mode compare timer
// assumes a 32-bit ahb-lite slave port with one register per aligned word
package cmp_timer_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_CNT_H = 8'h08;
    localparam logic [7:0] OFF_CNT_L = 8'h0C;
    localparam logic [7:0] OFF_CMP_H = 8'h10;
    localparam logic [7:0] OFF_CMP_L = 8'h14;
    localparam logic [7:0] OFF_MISC = 8'h18;
    // ========================================
    // reset values
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h00;
    // ========================================
    // control fields
    localparam int CTRL_LVL_H = 7;
    localparam int CTRL_SEL_H = 4;
    localparam int CTRL_LVL_L = 3;
    localparam int CTRL_SEL_L = 0;
    localparam int SEL_MSB = 2;
    // ========================================
    // control/status fields
    localparam int STAT_OVF_H = 7;
    localparam int STAT_CMF_H = 6;
    localparam int STAT_OVIE_H = 5;
    localparam int STAT_CCLR_H = 4;
    localparam int STAT_OVF_L = 3;
    localparam int STAT_CMF_L = 2;
    localparam int STAT_OVIE_L = 1;
    localparam int STAT_CCLR_L = 0;
    // ========================================
    // misc register fields
    localparam int MISC_IEN_H = 0;
    localparam int MISC_IEN_L = 1;
    localparam int MISC_EDGE = 2;
    localparam int MISC_SUBMODE = 3;
    // ========================================
    // clock sources and prescaler masks
    typedef enum logic [1:0] {
        SRC_DIV32, SRC_DIV16, SRC_DIV4, SRC_SUB4
    } clk_src_t;
    localparam int PRESC_W = 5;
    localparam logic [4:0] MASK_DIV32 = 5'h1F;
    localparam logic [4:0] MASK_DIV16 = 5'h0F;
    localparam logic [4:0] MASK_DIV4 = 5'h03;
    localparam logic [1:0] MASK_SUB4 = 2'h3;
    // ========================================
    // bus codes and the all-ones byte
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
endpackage : cmp_timer_pkg

//--- tb/cpu_bus_model.sv
// cpu side of the register bus: one single word transfer per request
// assumes one slave whose hreadyout is fed back as hready_in
`timescale 1ns/10ps
module cpu_bus_model (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic req_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic done_out,
    output logic [31:0] rdata_out,
    output logic [7:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    import cmp_timer_pkg::*;
    logic [1:0] st_q;
    logic [31:0] wd_q;
    always_ff @(posedge mclk_in) begin
        done_out <= 1'b0;
        if (srst_in) begin
            st_q <= 2'h0;
            htrans_out <= 2'h0;
            haddr_out <= 8'h00;
            hwrite_out <= 1'b0;
            hsize_out <= HSIZE_WORD;
            hwdata_out <= 32'h5A5A_5A5A;
            rdata_out <= 32'h0;
        end else begin
            case (st_q)
                2'h0: if (req_in) begin
                    htrans_out <= 2'h2;
                    haddr_out <= addr_in;
                    hwrite_out <= wr_in;
                    wd_q <= wdata_in;
                    st_q <= 2'h1;
                end
                2'h1: if (hready_in) begin
                    htrans_out <= 2'h0;
                    hwdata_out <= wd_q;
                    st_q <= 2'h2;
                end
                default: if (hready_in) begin
                    // released data lines show a changed value
                    hwdata_out <= ~hwdata_out;
                    rdata_out <= hrdata_in;
                    done_out <= 1'b1;
                    st_q <= 2'h0;
                end
            endcase
        end
    end
endmodule : cpu_bus_model

//--- tb/dual_mode_compare_timer_tb_top.sv
// self-checking bench for the dual-mode compare timer
// assumes the cpu bus model above as the only bus master
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; \
    if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %h seen %h", nm, e, g); end end
module dual_mode_compare_timer_tb_top;
    import cmp_timer_pkg::*;
    logic mclk_in = 1'b0, srst_in = 1'b1, req = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00, haddr;
    logic [31:0] wdata = 32'h0, hwdata, hrdata, rdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hwrite, hready, hresp, done, evt = 1'b0, sub = 1'b0;
    logic tog_h, tog_l, irq_h, irq_l;
    logic [7:0] eq[$];
    int n_fail = 0, total_checks = 0, seed = 32'h0ae56fdd, n, c, k;
    logic [15:0] v;
    initial forever #10 mclk_in = ~mclk_in;
    cpu_bus_model cpu (.mclk_in(mclk_in), .srst_in(srst_in), .req_in(req),
        .wr_in(wr), .addr_in(addr), .wdata_in(wdata), .hready_in(hready),
        .hrdata_in(hrdata), .done_out(done), .rdata_out(rdata),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));
    cmp_timer DUT (.mclk_in(mclk_in), .srst_in(srst_in), .hsel_in(1'b1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .event_count_input_in(evt), .subclk_in(sub),
        .toggle_out_upper_out(tog_h), .toggle_out_lower_out(tog_l),
        .irq_upper_out(irq_h), .irq_lower_out(irq_l));
    // ========================================
    // read results against the oldest note
    always @(posedge mclk_in) begin
        #1;
        if (done === 1'b1 && !wr) begin
            if (eq.size() == 0) `CHK("unexpected read", 1'b0, 1'b1)
            else `CHK("read data", {24'h0, eq.pop_front()}, rdata)
            `CHK("response", 1'b0, hresp)
        end
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int i;
        @(posedge mclk_in);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= {24'($random(seed)), d};
        @(posedge mclk_in);
        req <= 1'b0;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk_in);
            #1;
            if (done === 1'b1) break;
        end
        if (i == 50) `CHK("bus answer", 1'b1, 1'b0)
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        eq.push_back(e);
        xfer(1'b0, a, 8'h00);
    endtask : rd
    task automatic pulse(input int m);
        @(posedge mclk_in);
        repeat (m) begin
            evt <= 1'b1;
            repeat (2) @(posedge mclk_in);
            evt <= 1'b0;
            repeat (2) @(posedge mclk_in);
        end
        repeat (6) @(posedge mclk_in);
    endtask : pulse
    task automatic wait_tog(output int cnt);
        logic p;
        p = tog_l;
        for (cnt = 0; cnt < 700; cnt++) begin
            @(posedge mclk_in);
            #1;
            if (tog_l !== p) break;
        end
    endtask : wait_tog
    task automatic conclude;
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (60000) @(posedge mclk_in);
        n_fail++;
        conclude();
    end
    // ========================================
    initial begin
        repeat (10) @(posedge mclk_in);
        srst_in <= 1'b0;
        // reset values and an unmapped word
        rd(OFF_CTRL, CTRL_RST);
        rd(OFF_STAT, STAT_RST);
        rd(OFF_CNT_H, CNT_RST[15:8]);
        rd(OFF_CNT_L, CNT_RST[7:0]);
        rd(OFF_CMP_H, CMP_RST[15:8]);
        rd(OFF_CMP_L, CMP_RST[7:0]);
        rd(OFF_MISC, MISC_RST);
        rd(8'h1C, 8'h00);
        // writing ones to the flags leaves them clear
        xfer(1'b1, OFF_STAT, 8'hCC);
        rd(OFF_STAT, 8'h00);
        // 16-bit count written upper first, stopped on event input
        v = 16'($random(seed));
        xfer(1'b1, OFF_CNT_H, v[15:8]);
        xfer(1'b1, OFF_CNT_L, v[7:0]);
        rd(OFF_CNT_H, v[15:8]);
        rd(OFF_CNT_L, v[7:0]);
        // 16-bit event count across the wrap, rising edges
        xfer(1'b1, OFF_MISC, 8'h05);
        xfer(1'b1, OFF_STAT, 8'h20);
        xfer(1'b1, OFF_CNT_H, 8'hFF);
        xfer(1'b1, OFF_CNT_L, 8'hFE);
        pulse(1);
        rd(OFF_STAT, 8'h20);
        pulse(2);
        rd(OFF_STAT, 8'hEC);
        rd(OFF_CNT_H, 8'h00);
        rd(OFF_CNT_L, 8'h01);
        `CHK("irq upper", 1'b1, irq_h)
        `CHK("upper pin", 1'b1, tog_h)
        xfer(1'b1, OFF_STAT, 8'h20);
        rd(OFF_STAT, 8'h20);
        `CHK("irq upper", 1'b0, irq_h)
        // falling edge select
        xfer(1'b1, OFF_MISC, 8'h01);
        pulse(1);
        rd(OFF_CNT_H, 8'h00);
        rd(OFF_CNT_L, 8'h02);
        // 16-bit compare written upper first, clear on full match
        xfer(1'b1, OFF_CMP_H, 8'h00);
        xfer(1'b1, OFF_CMP_L, 8'h03);
        rd(OFF_CMP_H, 8'h00);
        rd(OFF_CMP_L, 8'h03);
        xfer(1'b1, OFF_STAT, 8'h10);
        pulse(2);
        rd(OFF_STAT, 8'h54);
        rd(OFF_CNT_H, 8'h00);
        rd(OFF_CNT_L, 8'h00);
        `CHK("upper pin", 1'b0, tog_h)
        // 8-bit lower half, clear on match, each internal divider
        xfer(1'b1, OFF_CTRL, 8'h70);
        c = 1 + ({$random(seed)} % 7);
        xfer(1'b1, OFF_CMP_L, 8'(c));
        xfer(1'b1, OFF_CNT_L, 8'h00);
        xfer(1'b1, OFF_STAT, 8'h01);
        for (k = 0; k < 3; k++) begin
            xfer(1'b1, OFF_CTRL, 8'h7C | 8'(k));
            repeat (2) @(posedge mclk_in);
            #1;
            if (k == 0) `CHK("lower pin level", 1'b1, tog_l)
            wait_tog(n);
            wait_tog(n);
            v = 16'((c + 1) * (32 >> (k + k / 2)));
            `CHK("toggle period", v, 16'(n + 1))
            rd(OFF_STAT, 8'h05);
        end
        `CHK("irq lower masked", 1'b0, irq_l)
        xfer(1'b1, OFF_MISC, 8'h02);
        `CHK("irq lower", 1'b1, irq_l)
        // sub-clock mode: only the sub-clock source counts
        xfer(1'b1, OFF_MISC, 8'h0A);
        xfer(1'b1, OFF_CTRL, 8'h76);
        xfer(1'b1, OFF_CNT_L, 8'h00);
        repeat (100) @(posedge mclk_in);
        rd(OFF_CNT_L, 8'h00);
        xfer(1'b1, OFF_CTRL, 8'h77);
        xfer(1'b1, OFF_CNT_L, 8'h00);
        @(posedge mclk_in);
        repeat (4) begin
            sub <= 1'b1;
            repeat (4) @(posedge mclk_in);
            sub <= 1'b0;
            repeat (3) @(posedge mclk_in);
        end
        repeat (10) @(posedge mclk_in);
        rd(OFF_CNT_L, 8'h01);
        repeat (3) @(posedge mclk_in);
        conclude();
    end
endmodule : dual_mode_compare_timer_tb_top
